// ===== verilog/core_halt_run_power_control.v
// halt/run activity-state control with power and debug arbitration
`timescale 1ns/10ps
`default_nettype none
`include "core_power_consts.vh"
module core_halt_run_power_control #(
   parameter QUIESCE = `QUIESCE_CYCLES
) (
   input wire clk,
   input wire nrst,
   input wire ce,
   input wire cpu_halt_req,
   input wire cpu_run_req,
   input wire mpc_debug_halt_req,
   input wire mpc_debug_run_req,
   input wire dbg_halt_req,
   input wire dbg_single_step,
   input wire dbg_brkpt_halt,
   input wire dbg_trigger_halt,
   input wire dbg_resume_req,
   input wire fw_halt_req,
   output reg cpu_halt_ack,
   output reg cpu_run_ack,
   output reg cpu_halt_status,
   output reg debug_mode_status,
   output wire [`ST_WIDTH-1:0] activity_state
);
   // ==========================================================
   // input synchronisers
   // ==========================================================
   wire halt_req_s;
   wire run_req_s;
   wire mpc_halt_s;
   wire mpc_run_s;
   // power halt request synchroniser
   req_sync #(.STAGES(`SYNC_STAGES)) u_sync_halt (
      .clk(clk), .nrst(nrst), .ce(ce),
      .async_in(cpu_halt_req), .sync_out(halt_req_s));
   // run request synchroniser sits on the free clock so wakeup works
   req_sync #(.STAGES(`SYNC_STAGES)) u_sync_run (
      .clk(clk), .nrst(nrst), .ce(1'b1),
      .async_in(cpu_run_req), .sync_out(run_req_s));
   // controller debug requests
   req_sync #(.STAGES(`SYNC_STAGES)) u_sync_mhalt (
      .clk(clk), .nrst(nrst), .ce(ce),
      .async_in(mpc_debug_halt_req), .sync_out(mpc_halt_s));
   req_sync #(.STAGES(`SYNC_STAGES)) u_sync_mrun (
      .clk(clk), .nrst(nrst), .ce(ce),
      .async_in(mpc_debug_run_req), .sync_out(mpc_run_s));

   // ==========================================================
   // debug entry and exit causes
   // ==========================================================
   // single step also resumes, so it counts as an entry, not exit
   wire debug_enter = dbg_halt_req | dbg_single_step | dbg_brkpt_halt |
      dbg_trigger_halt | mpc_halt_s;
   wire debug_exit = (dbg_resume_req & ~dbg_single_step) | mpc_run_s;

   // ==========================================================
   // state machine
   // ==========================================================
   reg [`ST_WIDTH-1:0] state_reg;
   reg [`ST_WIDTH-1:0] state_next;
   reg fw_halt_reg;
   wire quiesce_done;
   wire in_debug = (state_reg == `ST_DEBUG_HALTED);
   // firmware halt shares the power halt path but is masked in debug
   wire fw_halt_ok = fw_halt_req & ~in_debug;
   wire halt_cause = halt_req_s | fw_halt_reg;

   quiesce_timer #(.CYCLES(QUIESCE)) u_quiesce (
      .clk(clk), .nrst(nrst), .ce(ce),
      .start(state_reg == `ST_QUIESCE),
      .abort(debug_enter),
      .done(quiesce_done));

   // next-state: debug checks come first everywhere
   always @* begin
      state_next = state_reg;
      case (state_reg)
         `ST_RUNNING: begin
            if (debug_enter) begin
               state_next = `ST_DEBUG_HALTED;
            end else if (halt_cause) begin
               state_next = `ST_QUIESCE;
            end
         end
         `ST_QUIESCE: begin
            if (debug_enter) begin
               state_next = `ST_DEBUG_HALTED;
            end else if (quiesce_done) begin
               state_next = `ST_POWER_HALTED;
            end
         end
         `ST_POWER_HALTED: begin
            if (debug_enter) begin
               state_next = `ST_DEBUG_HALTED;
            end else if (run_req_s) begin
               state_next = `ST_RUNNING;
            end
         end
         `ST_DEBUG_HALTED: begin
            // halt requests do not leave here; on exit a held halt request goes to quiesce
            if (debug_exit && !debug_enter) begin
               if (halt_req_s) begin
                  state_next = `ST_QUIESCE;
               end else begin
                  state_next = `ST_RUNNING;
               end
            end else begin
               state_next = `ST_DEBUG_HALTED;
            end
         end
         default: begin
            state_next = `ST_RUNNING;
         end
      endcase
   end

   // state register and firmware halt latch
   always @(posedge clk) begin
      if (!nrst) begin
         state_reg <= `ST_RUNNING;
         fw_halt_reg <= 1'b0;
      end else if (ce) begin
         state_reg <= state_next;
         // cleared on debug entry so nothing stays pending at exit
         if (in_debug || debug_enter) begin
            fw_halt_reg <= 1'b0;
         end else if (fw_halt_ok) begin
            fw_halt_reg <= 1'b1;
         end else if (state_next == `ST_POWER_HALTED) begin
            fw_halt_reg <= 1'b0;
         end
      end
   end
   assign activity_state = state_reg;

   // ==========================================================
   // handshake acknowledges and status
   // ==========================================================
   // a transition caused by the manager arms the matching ack
   wire halt_done = (state_reg == `ST_QUIESCE) &&
      (state_next == `ST_POWER_HALTED) && halt_req_s;
   wire run_done = (state_reg == `ST_POWER_HALTED) &&
      (state_next == `ST_RUNNING) && run_req_s;

   always @(posedge clk) begin
      if (!nrst) begin
         cpu_halt_ack <= 1'b0;
         cpu_run_ack <= 1'b0;
         cpu_halt_status <= 1'b0;
         debug_mode_status <= 1'b0;
      end else if (ce) begin
         // ack set on the same edge that enters the halted state
         if (halt_done) begin
            cpu_halt_ack <= 1'b1;
         end else if (!halt_req_s) begin
            cpu_halt_ack <= 1'b0;
         end
         // requests to the state already held never set an ack
         if (run_done) begin
            cpu_run_ack <= 1'b1;
         end else if (!run_req_s) begin
            cpu_run_ack <= 1'b0;
         end
         cpu_halt_status <= (state_next == `ST_POWER_HALTED);
         debug_mode_status <= (state_next == `ST_DEBUG_HALTED);
      end
   end
endmodule
`default_nettype wire

// ===== verilog/core_power_consts.vh
// constants shared by the halt/run power control block
`ifndef CORE_POWER_CONSTS_VH
`define CORE_POWER_CONSTS_VH
// activity states
`define ST_RUNNING 2'h0
`define ST_QUIESCE 2'h1
`define ST_POWER_HALTED 2'h2
`define ST_DEBUG_HALTED 2'h3
`define ST_WIDTH 2
// synchroniser depth
`define SYNC_STAGES 2
// default quiesce wait in cycles
`define QUIESCE_CYCLES 4
`define QCNT_WIDTH 4
`define QCNT_ONE 4'h1
`define QCNT_ZERO 4'h0
`endif

// ===== verilog/req_sync.v
// two-flop level synchroniser for asynchronous request inputs
`timescale 1ns/10ps
`default_nettype none
module req_sync #(
   parameter STAGES = 2
) (
   input wire clk,
   input wire nrst,
   input wire ce,
   input wire async_in,
   output wire sync_out
);
   // ==========================================================
   // synchroniser chain
   // ==========================================================
   reg [STAGES-1:0] chain_reg;
   // first stage feeds only the second; nothing else looks at it
   always @(posedge clk) begin
      if (!nrst) begin
         chain_reg <= {STAGES{1'b0}};
      end else if (ce) begin
         chain_reg <= {chain_reg[STAGES-2:0], async_in};
      end
   end
   assign sync_out = chain_reg[STAGES-1];
endmodule
`default_nettype wire

// ===== verilog/quiesce_timer.v
// down counter that models the core draining before a power halt
`timescale 1ns/10ps
`default_nettype none
`include "core_power_consts.vh"
module quiesce_timer #(
   parameter CYCLES = `QUIESCE_CYCLES
) (
   input wire clk,
   input wire nrst,
   input wire ce,
   input wire start,
   input wire abort,
   output wire done
);
   // ==========================================================
   // counter
   // ==========================================================
   localparam [`QCNT_WIDTH-1:0] LOAD = CYCLES[`QCNT_WIDTH-1:0];
   reg [`QCNT_WIDTH-1:0] cnt_reg;
   reg busy_reg;
   // abort wins so a debug entry cancels the drain at once
   always @(posedge clk) begin
      if (!nrst) begin
         cnt_reg <= `QCNT_ZERO;
         busy_reg <= 1'b0;
      end else if (ce) begin
         if (abort) begin
            busy_reg <= 1'b0;
            cnt_reg <= `QCNT_ZERO;
         end else if (!start) begin
            // back to idle once the drain state is left, else the next
            // halt would see a stale done and skip its drain
            busy_reg <= 1'b0;
            cnt_reg <= `QCNT_ZERO;
         end else if (!busy_reg) begin
            busy_reg <= 1'b1;
            cnt_reg <= LOAD;
         end else if (cnt_reg != `QCNT_ZERO) begin
            cnt_reg <= cnt_reg - `QCNT_ONE;
         end
      end
   end
   assign done = busy_reg && (cnt_reg == `QCNT_ZERO) && !abort;
endmodule
`default_nettype wire

// ===== verif/power_ctl_chk_sva.sv
// assertions on the ports of the halt/run power control block
`timescale 1ns/10ps
`default_nettype none
module power_ctl_chk #(
   parameter QUIESCE = 4
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   input wire logic cpu_halt_req,
   input wire logic dbg_halt_req,
   input wire logic dbg_single_step,
   input wire logic dbg_brkpt_halt,
   input wire logic dbg_trigger_halt,
   input wire logic cpu_halt_ack,
   input wire logic cpu_run_ack,
   input wire logic cpu_halt_status,
   input wire logic debug_mode_status,
   input wire logic [1:0] activity_state
);
   logic [7:0] qcnt_reg;
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   // ==========
   // drain length; frozen with the enable so stalls do not skew it
   always_ff @(posedge clk)
      if (!nrst) qcnt_reg <= 8'h00;
      else if (ce) qcnt_reg <= (activity_state == 2'h1) ?
         qcnt_reg + 8'h01 : 8'h00;
   sequence s_quiesce_end;
      activity_state == 2'h2 && $past(activity_state) == 2'h1;
   endsequence
   sequence s_dbg_cause;
      ce && (dbg_halt_req || dbg_single_step || dbg_brkpt_halt ||
         dbg_trigger_halt);
   endsequence
   chk_halt_status: assert property (
      cpu_halt_status == (activity_state == 2'h2)) else $error("halt status");
   chk_dbg_status: assert property (
      debug_mode_status == (activity_state == 2'h3)) else $error("dbg status");
   chk_ack_order: assert property (
      $rose(cpu_halt_ack) |-> s_quiesce_end) else $error("early halt ack");
   chk_quiesce_len: assert property (
      s_quiesce_end |-> qcnt_reg == QUIESCE + 2) else $error("drain length");
   chk_ack_release: assert property (
      $fell(cpu_halt_ack) |-> !$past(cpu_halt_req, 2)) else $error("ack drop");
   chk_run_ack: assert property (
      $rose(cpu_run_ack) |-> activity_state == 2'h0 &&
      $past(activity_state) == 2'h2) else $error("run ack");
   chk_dbg_entry: assert property (
      s_dbg_cause |=> activity_state == 2'h3) else $error("no debug entry");
   chk_no_pwr_dbg: assert property (
      activity_state == 2'h3 |=> activity_state != 2'h2) else $error("halt");
endmodule
bind core_halt_run_power_control power_ctl_chk #(.QUIESCE(QUIESCE)) chk_i (
   .clk, .nrst, .ce, .cpu_halt_req, .dbg_halt_req, .dbg_single_step,
   .dbg_brkpt_halt, .dbg_trigger_halt, .cpu_halt_ack, .cpu_run_ack,
   .cpu_halt_status, .debug_mode_status, .activity_state);
`default_nettype wire

// ===== verif/pwr_mgr_model.sv
// behavioural power manager on the far side of the handshakes
`timescale 1ns/10ps
`default_nettype none
module pwr_mgr_model (
   input wire logic clk,
   input wire logic slow,
   input wire logic want_halt,
   input wire logic want_run,
   input wire logic cpu_halt_ack,
   input wire logic cpu_run_ack,
   output logic cpu_halt_req = 1'b0,
   output logic cpu_run_req = 1'b0
);
   logic [3:0] hs_reg = 4'h0;
   logic [3:0] rs_reg = 4'h0;
   logic hw_reg = 1'b0;
   logic rw_reg = 1'b0;
   // ==========
   // acks re-timed here first; slow mode waits two extra stages
   always @(posedge clk) begin
      hs_reg <= {hs_reg[2:0], cpu_halt_ack};
      rs_reg <= {rs_reg[2:0], cpu_run_ack};
      hw_reg <= want_halt;
      rw_reg <= want_run;
      // idle low, active high, neither raised while the other is already high
      if (want_halt && !hw_reg && !cpu_run_req) cpu_halt_req <= 1'b1;
      else if (!want_halt || hs_reg[slow ? 3 : 1]) cpu_halt_req <= 1'b0;
      if (want_run && !rw_reg && !cpu_halt_req) cpu_run_req <= 1'b1;
      else if (!want_run || rs_reg[slow ? 3 : 1]) cpu_run_req <= 1'b0;
   end
endmodule
`default_nettype wire

// ===== verif/core_halt_run_power_control_tb_top.sv
// self-checking bench for the halt/run power control block
`timescale 1ns/10ps
`default_nettype none
module core_halt_run_power_control_tb_top;
   logic clk = 1'b0, nrst = 1'b0, ce = 1'b1, wh = 1'b0, wr = 1'b0;
   logic slow = 1'b0, hreq, rreq, hack, rack, hst, dst;
   logic [7:0] dv = 8'h00;
   logic [1:0] st;
   int err_count = 0, tests_run = 0, cycles = 0;
   // ==========
   // clock and hang guard
   always #12.5 clk = ~clk;
   always @(posedge clk) begin
      cycles++;
      if (cycles > 6000) begin
         err_count++;
         close_out();
      end
   end
   core_halt_run_power_control #(.QUIESCE(4)) uut (.clk(clk), .nrst(nrst),
      .ce(ce), .cpu_halt_req(hreq), .cpu_run_req(rreq),
      .mpc_debug_halt_req(dv[6]), .mpc_debug_run_req(dv[7]),
      .dbg_halt_req(dv[0]), .dbg_single_step(dv[1]),
      .dbg_brkpt_halt(dv[2]), .dbg_trigger_halt(dv[3]),
      .dbg_resume_req(dv[4]), .fw_halt_req(dv[5]), .cpu_halt_ack(hack),
      .cpu_run_ack(rack), .cpu_halt_status(hst),
      .debug_mode_status(dst), .activity_state(st));
   pwr_mgr_model pm (.clk(clk), .slow(slow), .want_halt(wh),
      .want_run(wr), .cpu_halt_ack(hack), .cpu_run_ack(rack),
      .cpu_halt_req(hreq), .cpu_run_req(rreq));
   // ==========
   // shared steps; inputs move 2 ns after the edge
   task close_out;
      $display("checks %0d errors %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task cmp(input string nm, input logic [1:0] e, g);
      tests_run++;
      if (g !== e) begin
         err_count++;
         $display("MISMATCH %s exp %h got %h", nm, e, g);
      end
   endtask
   task cyc(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask
   task wt(input logic [1:0] s);
      for (int i = 0; i < 60 && st !== s; i++) cyc(1);
   endtask
   task pl(input int k, n);
      dv[k] = 1'b1;
      cyc(n);
      dv[k] = 1'b0;
   endtask
   // ==========
   // scenarios
   task t_run;
      wr = 1'b1;
      wt(2'h0);
      cmp("run", 2'h2, {rack, hst});
      cyc(10);
      cmp("run ack", 2'h0, {hst, rack});
      wr = 1'b0;
      cyc(2);
      // a fresh run request while already running
      wr = 1'b1;
      cyc(10);
      cmp("again", 2'h0, {st[1], rack});
      wr = 1'b0;
      cyc(2);
   endtask
   task t_halt_run;
      wh = 1'b1;
      wt(2'h2);
      cmp("halted", 2'h3, {hst, hack});
      cyc(10);
      cmp("halt ack", 2'h0, {dst, hack});
      wh = 1'b0;
      cyc(2);
      wh = 1'b1;
      cyc(10);
      cmp("no ack", 2'h0, {1'b0, hack});
      wh = 1'b0;
      // let the halt request fall first, the manager raises no run request while it is high
      cyc(2);
      t_run;
   endtask
   // halt held across debug, honoured on exit; abort mid drain
   task t_dbg_block(input int drain);
      wh = 1'b1;
      if (drain) wt(2'h1);
      pl(0, 1);
      cyc(8);
      cmp("dbg hold", 2'h3, st);
      cmp("dbg ack", 2'h2, {dst, hack});
      pl(4, 1);
      wt(2'h2);
      cmp("late halt", 2'h2, st);
      cyc(10);
      wh = 1'b0;
      t_run;
   endtask
   task t_causes;
      for (int k = 0; k < 7; k++) begin
         if (k == 4 || k == 5) continue;
         pl(k, 3);
         cyc(3);
         cmp("entry", 2'h3, st);
         pl(k == 6 ? 7 : 4, 3);
         cyc(4);
         cmp("exit", 2'h0, st);
      end
   endtask
   task t_fw;
      pl(0, 1);
      pl(5, 2);
      pl(4, 1);
      cyc(8);
      cmp("fw drop", 2'h0, st);
      // firmware halt outside debug: halted, but no manager ack
      pl(5, 1);
      wt(2'h2);
      cmp("fw halt", 2'h2, {hst, hack});
      // enable low: state frozen, run synchroniser still clocked
      ce = 1'b0;
      wr = 1'b1;
      cyc(6);
      cmp("frozen", 2'h2, st);
      ce = 1'b1;
      cyc(1);
      cmp("wake", 2'h0, st);
      cyc(10);
      wr = 1'b0;
      cyc(2);
   endtask
   initial begin
      cyc(16);
      nrst = 1'b1;
      cyc(3);
      cmp("reset", 2'h0, st);
      t_halt_run;
      slow = 1'b1;
      t_halt_run;
      t_dbg_block(0);
      t_dbg_block(1);
      t_causes;
      t_fw;
      close_out();
   end
endmodule
`default_nettype wire
